// ==== include/lcrc_pkg.sv ====
// Package: shared constants and types of the logic cell register control block
package lcrc_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CLKMAP  = 8'h04;
  localparam logic [7:0] OFS_CEMAP   = 8'h08;
  localparam logic [7:0] OFS_OEMAP   = 8'h0c;
  localparam logic [7:0] OFS_PIN0    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h30;

  // ==========================================================================
  // Control and status register fields
  localparam int CTRL_MODE_POS   = 0;
  localparam int CTRL_CLRSEL_POS = 3;
  localparam int CTRL_POL_POS    = 4;
  localparam int CTRL_DINV_POS   = 6;
  localparam int CTRL_GSRC_POS   = 8;
  localparam int SLOT_W          = 4;
  localparam int STAT_CELL_POS   = 16;
  localparam int STAT_TBUS_POS   = 18;
  localparam int STAT_CARRY_POS  = 19;
  localparam int STAT_PIN_POS    = 20;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] CLKMAP_RST = 16'hffff;
  localparam logic [23:0] CEMAP_RST  = 24'hff_ffff;
  localparam logic [31:0] OEMAP_RST  = 32'hffff_ffff;
  localparam logic [11:0] PINCFG_RST = 12'h770;

  // ==========================================================================
  // Peripheral control bus shape
  localparam int PCB_W    = 12;
  localparam int PCB_OE_N = 8;
  localparam int PCB_CE_N = 6;
  localparam int PCB_CK_N = 2;
  localparam int PCB_CL_N = 2;
  localparam int GLB_N    = 4;

  // Counter lookup tables, indexed by {enable, carry in, current bit}
  localparam logic [7:0] LUT_DATA  = 8'h6a;
  localparam logic [7:0] LUT_CARRY = 8'h88;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    MODE_CLR, MODE_PRE, MODE_CLR_PRE, MODE_LOAD_CLR, MODE_LOAD_PRE, MODE_LOAD
  } lcrc_mode_t;

  typedef struct packed {
    logic       oe_direct;
    logic [2:0] oe_slot;
    logic       ce_direct;
    logic [2:0] ce_slot;
    logic       clr_en;
    logic       clr_slot;
    logic [1:0] clk_src;
  } lcrc_pin_cfg_t;

endpackage

// ==== verilog/lcrc_cell_reg.sv ====
// Logic cell storage element with async-style clear, preset and load overrides
`timescale 1ns/100ps
`default_nettype none
module lcrc_cell_reg (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Cell clock event and data
  input  wire logic i_tick,
  input  wire logic i_d,
  // Overrides
  input  wire logic i_clr_b,
  input  wire logic i_pre_b,
  input  wire logic i_aload,
  input  wire logic i_adata,
  // Output
  output logic      o_q
);

  // ==========================================================================
  // Storage
  // Overrides act on the system clock, not the cell clock, so they do not
  // wait for a cell clock event
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_q <= 1'b0;
    end else if (!i_clr_b) begin
      o_q <= 1'b0;
    end else if (!i_pre_b) begin
      o_q <= 1'b1;
    end else if (i_aload) begin
      o_q <= i_adata;
    end else if (i_tick) begin
      o_q <= i_d;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/lcrc_top.sv ====
// Logic cell and pin cell register control with an AHB-Lite register port
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module lcrc_top
  import lcrc_pkg::*;
#(
  parameter int GROUPS  = 2,
  parameter int PINS    = 4,
  parameter int CNT_W   = 8,
  parameter int DRIVERS = 4
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // AHB-Lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic      [31:0]          o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  // Dedicated pins (asynchronous)
  input  wire logic [1:0]           i_ded_clk,
  input  wire logic [GLB_N-1:0]     i_ded_global,
  input  wire logic                 i_chip_clr_b,
  input  wire logic [GROUPS-1:0]    i_block_control_first,
  input  wire logic [GROUPS-1:0]    i_block_control_second,
  input  wire logic [GROUPS-1:0]    i_async_load_data,
  // User logic (same clock)
  input  wire logic [GROUPS-1:0]    i_cell_d,
  input  wire logic                 i_cnt_en,
  input  wire logic                 i_cnt_sload,
  input  wire logic                 i_cnt_sclr_b,
  input  wire logic [CNT_W-1:0]     i_cnt_load_data,
  input  wire logic [DRIVERS-1:0]   i_drv_data,
  input  wire logic [DRIVERS-1:0]   i_drv_en,
  input  wire logic [PCB_W-1:0]     i_pcb,
  input  wire logic [PINS-1:0]      i_cell_ce,
  input  wire logic [PINS-1:0]      i_cell_oe,
  input  wire logic [PINS-1:0]      i_pin_d,
  input  wire logic [GLB_N-1:0]     i_int_global,
  // Results
  output logic      [GROUPS-1:0]    o_cell_q,
  output logic      [CNT_W-1:0]     o_cnt,
  output logic                      o_carry,
  output logic                      o_tbus,
  output logic      [PINS-1:0]      o_pin_q,
  output logic      [PINS-1:0]      o_pin_oe,
  output logic      [GLB_N-1:0]     o_global
);

  // ==========================================================================
  // Pin synchronisers
  localparam int SW = 2 + GLB_N + 1 + 3 * GROUPS;
  localparam logic [SW-1:0] SYNC_RST = {{(2 * GROUPS){1'b1}}, {GROUPS{1'b0}}, 1'b1,
                                        {(GLB_N + 2){1'b0}}};
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [1:0]        ded_clk;
  logic [GLB_N-1:0]  ded_glb;
  logic              chip_clr_b;
  logic [GROUPS-1:0] ctl1;
  logic [GROUPS-1:0] ctl2;
  logic [GROUPS-1:0] adata;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end else begin
      sync1 <= {i_block_control_second, i_block_control_first, i_async_load_data,
                i_chip_clr_b, i_ded_global, i_ded_clk};
      sync2 <= sync1;
    end
  end
  assign {ctl2, ctl1, adata, chip_clr_b, ded_glb, ded_clk} = sync2;

  // ==========================================================================
  // Configuration registers
  lcrc_mode_t                  mode;
  logic                        clr_sel;
  logic [GROUPS-1:0]           grp_inv;
  logic                        ded_inv;
  logic [GLB_N-1:0]            glb_int;
  logic [15:0]                 clk_map;
  logic [23:0]                 ce_map;
  logic [31:0]                 oe_map;
  lcrc_pin_cfg_t [PINS-1:0]    pin_cfg;

  // AHB address phase capture
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        map_hit;
  logic        pin_hit;
  logic [7:0]  pin_idx;
  logic        req;
  logic [31:0] rd_mux;
  logic [31:0] status;

  assign req         = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= req & i_hwrite & (i_haddr[31:8] == 24'h000000);
      wr_addr <= i_haddr[7:0];
    end
  end

  assign pin_idx = 8'((wr_addr - OFS_PIN0) >> 2);
  assign pin_hit = (wr_addr >= OFS_PIN0) && (pin_idx < 8'(PINS)) && (wr_addr[1:0] == 2'b00);

  // Out-of-range mode codes fall back to clear only
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mode    <= MODE_CLR;
      clr_sel <= CTRL_RST[CTRL_CLRSEL_POS];
      grp_inv <= CTRL_RST[CTRL_POL_POS +: GROUPS];
      ded_inv <= CTRL_RST[CTRL_DINV_POS];
      glb_int <= CTRL_RST[CTRL_GSRC_POS +: GLB_N];
    end else if (wr_pend && wr_addr == OFS_CTRL) begin
      mode    <= (i_hwdata[CTRL_MODE_POS +: 3] > 3'(MODE_LOAD)) ? MODE_CLR :
                 lcrc_mode_t'(i_hwdata[CTRL_MODE_POS +: 3]);
      clr_sel <= i_hwdata[CTRL_CLRSEL_POS];
      grp_inv <= i_hwdata[CTRL_POL_POS +: GROUPS];
      ded_inv <= i_hwdata[CTRL_DINV_POS];
      glb_int <= i_hwdata[CTRL_GSRC_POS +: GLB_N];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      clk_map <= CLKMAP_RST;
      ce_map  <= CEMAP_RST;
      oe_map  <= OEMAP_RST;
    end else if (wr_pend) begin
      if (wr_addr == OFS_CLKMAP) begin
        clk_map <= i_hwdata[15:0];
      end
      if (wr_addr == OFS_CEMAP) begin
        ce_map <= i_hwdata[23:0];
      end
      if (wr_addr == OFS_OEMAP) begin
        oe_map <= i_hwdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_cfg <= {PINS{PINCFG_RST}};
    end else if (wr_pend && pin_hit) begin
      pin_cfg[pin_idx[2:0]] <= i_hwdata[11:0];
    end
  end

  // ==========================================================================
  // Read path: data registered in the address phase, valid in the data phase
  assign status = {4'h0, 8'(o_pin_q), o_carry, o_tbus, 2'(o_cell_q), 16'(o_cnt)};
  assign map_hit = (i_haddr[7:0] >= OFS_PIN0) &&
                   (8'((i_haddr[7:0] - OFS_PIN0) >> 2) < 8'(PINS));

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_haddr[31:8] == 24'h000000) begin
      case (i_haddr[7:0])
        OFS_CTRL:   rd_mux = 32'({glb_int, 1'b0, ded_inv, 2'(grp_inv), clr_sel, 3'(mode)}) <<
                             CTRL_MODE_POS;
        OFS_CLKMAP: rd_mux = {16'h0000, clk_map};
        OFS_CEMAP:  rd_mux = {8'h00, ce_map};
        OFS_OEMAP:  rd_mux = oe_map;
        OFS_STATUS: rd_mux = status;
        default: begin
          if (map_hit) begin
            rd_mux = {20'h00000, pin_cfg[3'((i_haddr[7:0] - OFS_PIN0) >> 2)]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_hrdata <= 32'h0000_0000;
    end else if (req && !i_hwrite) begin
      o_hrdata <= rd_mux;
    end
  end

  // ==========================================================================
  // Logic cell groups: clock polarity, clear/preset/load steering
  logic [1:0]        ded_prev;
  logic [GROUPS-1:0] grp_tick;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ded_prev <= 2'b00;
    end else begin
      ded_prev <= ded_clk;
    end
  end

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : gen_grp
      logic clr_src;
      logic pre_src;
      logic clr_b;
      logic pre_b;
      logic aload;
      logic load_mode;

      // Rising edge of the group's chosen sense of dedicated clock 0
      assign grp_tick[g] = (ded_clk[0] ^ grp_inv[g]) & ~(ded_prev[0] ^ grp_inv[g]);

      assign load_mode = (mode == MODE_LOAD_CLR) || (mode == MODE_LOAD_PRE) ||
                         (mode == MODE_LOAD);
      assign clr_src   = load_mode ? ctl2[g] : (clr_sel ? ctl2[g] : ctl1[g]);
      assign pre_src   = (clr_sel || load_mode) ? ctl1[g] : ctl2[g];
      assign clr_b = (mode == MODE_CLR || mode == MODE_CLR_PRE || mode == MODE_LOAD_CLR) ?
                     clr_src : 1'b1;
      assign pre_b = (mode == MODE_PRE || mode == MODE_CLR_PRE) ? pre_src :
                     (mode == MODE_LOAD_PRE) ? ctl2[g] : 1'b1;
      assign aload = load_mode & ctl1[g];

      lcrc_cell_reg u_cell (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_tick  (grp_tick[g]),
        .i_d     (i_cell_d[g]),
        .i_clr_b (clr_b),
        .i_pre_b (pre_b),
        .i_aload (aload),
        .i_adata (adata[g]),
        .o_q     (o_cell_q[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Clearable counter in group 0 cells
  logic [CNT_W:0]   carry;
  logic [CNT_W-1:0] lut_d;
  logic [CNT_W-1:0] next_cnt;

  // Clear occupies the cascade-in slot, so there is no direction control
  assign carry[0] = 1'b1;

  genvar b;
  generate
    for (b = 0; b < CNT_W; b++) begin : gen_cnt
      assign lut_d[b]     = LUT_DATA[{i_cnt_en, carry[b], o_cnt[b]}];
      assign carry[b + 1] = LUT_CARRY[{i_cnt_en, carry[b], o_cnt[b]}];
    end
  endgenerate

  assign next_cnt = (i_cnt_sload ? i_cnt_load_data : lut_d) &
                    {CNT_W{i_cnt_sclr_b}};

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_cnt   <= '0;
      o_carry <= 1'b0;
    end else if (grp_tick[0]) begin
      o_cnt   <= next_cnt;
      o_carry <= carry[CNT_W] & i_cnt_en;
    end
  end

  // ==========================================================================
  // Emulated internal tri-state bus, resolved by a selector
  logic       tbus_next;
  logic [7:0] en_cnt;

  always_comb begin
    tbus_next = 1'b1;
    en_cnt    = 8'h00;
    for (int d = 0; d < DRIVERS; d++) begin
      if (i_drv_en[d]) begin
        en_cnt    = en_cnt + 8'h01;
        tbus_next = i_drv_data[d];
      end
    end
    if (en_cnt > 8'h01) begin
      tbus_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_tbus <= 1'b1;
    end else begin
      o_tbus <= tbus_next;
    end
  end

  // ==========================================================================
  // Global signals
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_global <= '0;
    end else begin
      o_global <= (glb_int & i_int_global) | (~glb_int & ded_glb);
    end
  end

  // ==========================================================================
  // Pin cells fed from the peripheral control bus
  // Slot tables cap the roles: two clocks, two clears, six CE, eight OE
  function automatic logic pcb_pick(input logic [3:0] idx);
    pcb_pick = (idx < 4'(PCB_W)) ? i_pcb[idx] : 1'b0;
  endfunction

  // Clock slot codes 12..15 are the true and complement of each dedicated
  // clock, so using both senses costs both slots
  function automatic logic clk_pick(input logic [3:0] idx);
    case (idx)
      4'hc:    clk_pick = ded_clk[0];
      4'hd:    clk_pick = ~ded_clk[0];
      4'he:    clk_pick = ded_clk[1];
      4'hf:    clk_pick = ~ded_clk[1];
      default: clk_pick = i_pcb[idx];
    endcase
  endfunction

  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : gen_pin
      lcrc_pin_cfg_t cfg;
      logic          pclk;
      logic          pclk_prev;
      logic          ce;
      logic          clr;
      logic          oe;

      assign cfg = pin_cfg[p];

      always_comb begin
        case (cfg.clk_src)
          2'd0:    pclk = clk_pick(clk_map[0 +: SLOT_W]);
          2'd1:    pclk = clk_pick(clk_map[SLOT_W +: SLOT_W]);
          2'd2:    pclk = ded_clk[0] ^ ded_inv;
          default: pclk = ded_clk[1] ^ ded_inv;
        endcase
      end

      assign clr = cfg.clr_en &
                   pcb_pick(clk_map[(2 + 32'(cfg.clr_slot)) * SLOT_W +: SLOT_W]);
      assign ce  = cfg.ce_direct ? i_cell_ce[p] :
                   (cfg.ce_slot < 3'(PCB_CE_N)) ?
                   pcb_pick(ce_map[32'(cfg.ce_slot) * SLOT_W +: SLOT_W]) : 1'b1;
      assign oe  = cfg.oe_direct ? i_cell_oe[p] :
                   pcb_pick(oe_map[32'(cfg.oe_slot) * SLOT_W +: SLOT_W]);

      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          pclk_prev <= 1'b0;
        end else begin
          pclk_prev <= pclk;
        end
      end

      // Chip-wide reset sits above clear, clock and enable
      always_ff @(posedge i_clk) begin
        if (!i_rst_b || !chip_clr_b) begin
          o_pin_q[p] <= 1'b0;
        end else if (clr) begin
          o_pin_q[p] <= 1'b0;
        end else if (pclk && !pclk_prev && ce) begin
          o_pin_q[p] <= i_pin_d[p];
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_rst_b || !chip_clr_b) begin
          o_pin_oe[p] <= 1'b0;
        end else begin
          o_pin_oe[p] <= oe;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ==== tb/lcrc_chk.sv ====
// Checker: concurrent properties on the top-level ports
`timescale 1ns/100ps
`default_nettype none
module lcrc_chk #(
  parameter int CNT_W   = 8,
  parameter int DRIVERS = 4,
  parameter int PINS    = 4
) (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst_b,
  // Watched inputs
  input wire logic [DRIVERS-1:0] i_drv_en,
  input wire logic [DRIVERS-1:0] i_drv_data,
  input wire logic               i_chip_clr_b,
  input wire logic [1:0]         i_ded_clk,
  input wire logic               i_cnt_en,
  input wire logic               i_cnt_sload,
  input wire logic               i_cnt_sclr_b,
  input wire logic [CNT_W-1:0]   i_cnt_load_data,
  // Watched outputs
  input wire logic               o_hreadyout,
  input wire logic               o_hresp,
  input wire logic               o_tbus,
  input wire logic [CNT_W-1:0]   o_cnt,
  input wire logic [PINS-1:0]    o_pin_q,
  input wire logic [PINS-1:0]    o_pin_oe
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Two sync flops plus the register itself
  sequence s_clr_held; !i_chip_clr_b [*3]; endsequence
  sequence s_cnt_moved; $changed(o_cnt); endsequence
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  a_tbus_float: assert property (i_drv_en == '0 |=> o_tbus)
    else $error("idle bus not high");
  a_tbus_fight: assert property ($countones(i_drv_en) > 1 |=> !o_tbus)
    else $error("contended bus not low");
  a_tbus_single: assert property ($onehot(i_drv_en) |=>
    o_tbus == $past(|(i_drv_en & i_drv_data))) else $error("single driver lost");
  a_pin_reset: assert property (s_clr_held |=> o_pin_q == '0 && o_pin_oe == '0)
    else $error("pin cells survive chip clear");
  a_cnt_clear: assert property (s_cnt_moved ##0 !$past(i_cnt_sclr_b) |-> o_cnt == '0)
    else $error("count not cleared");
  a_cnt_load: assert property (s_cnt_moved ##0 ($past(i_cnt_sload) &&
    $past(i_cnt_sclr_b)) |-> o_cnt == $past(i_cnt_load_data)) else $error("bad load");
  a_cnt_step: assert property (s_cnt_moved ##0 ($past(i_cnt_en) && !$past(i_cnt_sload)
    && $past(i_cnt_sclr_b)) |-> o_cnt == CNT_W'($past(o_cnt) + 1)) else $error("bad step");
  a_cnt_still: assert property ($stable(i_ded_clk[0]) [*6] |-> $stable(o_cnt))
    else $error("count moved without a tick");
endmodule
`default_nettype wire

// ==== tb/lcrc_partner.sv ====
// Partner: dedicated clock pin source, one slow clock cycle per request
`timescale 1ns/100ps
`default_nettype none
module lcrc_partner (
  // Clock and request
  input  wire logic  i_clk,
  input  wire logic  i_go,
  // Dedicated clock pins
  output logic [1:0] o_ded_clk
);
  logic [3:0] cnt = 4'h0;
  // ==========================================================================
  // Still between requests; twelve cycles keeps it far below a quarter rate
  always_ff @(posedge i_clk) begin
    if (i_go && cnt == 4'h0) begin
      cnt <= 4'hc;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign o_ded_clk = {1'b0, cnt > 4'h6};
endmodule
`default_nettype wire

// ==== tb/lcrc_top_test.sv ====
// Testbench: bus tasks and directed scenarios for the register control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module lcrc_top_test
  import lcrc_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  logic        clr_b = 1'b1, cen = 1'b0, sload = 1'b0, sclr_b = 1'b1;
  logic [31:0] haddr = '0, hwdata = '0, rdata;
  logic [1:0]  htrans = '0, first = 2'b11, second = 2'b11, adata = '0, cell_d = '0;
  logic [3:0]  dglob = 4'h5, iglob = 4'ha, drv_d = '0, drv_e = '0, poe = '0, pd = '0;
  logic [7:0]  ldata = '0;
  logic [11:0] pcb = '0;
  wire  [31:0] hrdata;
  wire         hready, hresp, carry, tbus;
  wire  [1:0]  cell_q, dclk;
  wire  [3:0]  pin_q, pin_oe, glob;
  wire  [7:0]  cnt;
  int          error_cnt = 0, n_compared = 0, cyc = 0;

  lcrc_partner u_far (.i_clk(clk), .i_go(go), .o_ded_clk(dclk));
  lcrc_top dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_ded_clk(dclk),
    .i_ded_global(dglob), .i_chip_clr_b(clr_b), .i_block_control_first(first),
    .i_block_control_second(second), .i_async_load_data(adata), .i_cell_d(cell_d),
    .i_cnt_en(cen), .i_cnt_sload(sload), .i_cnt_sclr_b(sclr_b), .i_cnt_load_data(ldata),
    .i_drv_data(drv_d), .i_drv_en(drv_e), .i_pcb(pcb), .i_cell_ce(4'h0), .i_cell_oe(poe),
    .i_pin_d(pd), .i_int_global(iglob), .o_cell_q(cell_q), .o_cnt(cnt), .o_carry(carry),
    .o_tbus(tbus), .o_pin_q(pin_q), .o_pin_oe(pin_oe), .o_global(glob)
  );

  // ==========================================================================
  // Clock, watchdog and verdict
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
    ahb(1'b0, a, 32'h0);
    `CHK(nm, e, rdata)
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    tk(16);
    rst_b <= 1'b1;
    tk(1);
    rd_chk(OFS_CLKMAP, {16'h0, CLKMAP_RST}, "clkmap");
    rd_chk(OFS_CEMAP, {8'h0, CEMAP_RST}, "cemap");
    rd_chk(OFS_OEMAP, OEMAP_RST, "oemap");
    rd_chk(OFS_PIN0, {20'h0, PINCFG_RST}, "pincfg");
    ahb(1'b1, 32'h100, 32'hffff_ffff);
    rd_chk(32'h100, 32'h0, "unmapped");
    rd_chk(OFS_CTRL, CTRL_RST, "ctrl");
    for (int m = 0; m < 8; m++) begin
      ahb(1'b1, OFS_CTRL, 32'(m));
      tk(1);
      rd_chk(OFS_CTRL, (m < 6) ? 32'(m) : 32'h0, "mode");
    end
    // Emulated bus: none, one high, one low, two
    for (int k = 0; k < 4; k++) begin
      drv_e <= 4'(16'h6440 >> (4 * k));
      drv_d <= 4'(16'hfb4f >> (4 * k));
      tk(2);
      `CHK("tbus", 1'(4'b0011 >> k), tbus)
    end
    // Cell overrides: load, clear from second, preset with clear unused
    ahb(1'b1, OFS_CTRL, 32'h5);
    first <= 2'b01;
    adata <= 2'b01;
    tk(6);
    `CHK("load", 1'b1, cell_q[0])
    ahb(1'b1, OFS_CTRL, 32'h8);
    second <= 2'b10;
    tk(6);
    `CHK("clear", 1'b0, cell_q[0])
    ahb(1'b1, OFS_CTRL, 32'h9);
    first <= 2'b10;
    tk(6);
    `CHK("preset", 1'b1, cell_q[0])
    first <= 2'b11;
    second <= 2'b11;
    // Counter load, step, clear, step; pin clocked by dedicated pin
    ahb(1'b1, OFS_PIN0, 32'h772);
    pd <= 4'h1;
    cen <= 1'b1;
    ldata <= 8'hfe;
    for (int k = 0; k < 4; k++) begin
      sload <= (k == 0);
      sclr_b <= (k != 2);
      tk(1);
      go <= 1'b1;
      tk(1);
      go <= 1'b0;
      tk(16);
      `CHK("count", 8'(32'h0100fffe >> (8 * k)), cnt)
    end
    `CHK("pin clock", 1'b1, pin_q[0])
    // Output enable from the control bus, then straight from a cell
    pcb <= 12'h008;
    ahb(1'b1, OFS_OEMAP, 32'hffff_fff3);
    ahb(1'b1, OFS_PIN0, 32'h072);
    tk(3);
    `CHK("oe bus", 1'b1, pin_oe[0])
    pcb <= 12'h000;
    poe <= 4'h1;
    ahb(1'b1, OFS_PIN0, 32'h872);
    tk(3);
    `CHK("oe direct", 1'b1, pin_oe[0])
    clr_b <= 1'b0;
    tk(6);
    `CHK("chip clear", 8'h0, {pin_q, pin_oe})
    clr_b <= 1'b1;
    // Global sources
    ahb(1'b1, OFS_CTRL, 32'hf00);
    tk(6);
    `CHK("global int", iglob, glob)
    ahb(1'b1, OFS_CTRL, 32'h0);
    tk(6);
    `CHK("global pin", dglob, glob)
    print_verdict();
  end
endmodule

bind lcrc_top lcrc_chk #(.CNT_W(CNT_W), .DRIVERS(DRIVERS), .PINS(PINS)) u_chk (
  .i_clk, .i_rst_b, .i_drv_en, .i_drv_data, .i_chip_clr_b, .i_ded_clk, .i_cnt_en,
  .i_cnt_sload, .i_cnt_sclr_b, .i_cnt_load_data, .o_hreadyout, .o_hresp, .o_tbus,
  .o_cnt, .o_pin_q, .o_pin_oe
);
`default_nettype wire
